// ---- pkg/rsc_pkg.sv ----
// Purpose: shared constants and helpers of the radio serial port
// Assumes: both ends run on a 10 MHz system clock
// Notes: the serial clock is slow enough to be oversampled by that clock
package rsc_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 100;

    // serial clock made by the host: 4 + 4 cycles, 800 ns period
    localparam int SCLK_MAX_MHZ = 10;
    localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
    localparam int SCLK_HALF_CYCLES = 4;
    localparam int SEL_GAP_CYCLES = 8;

    // typical time from command to a ready clear-to-send value
    localparam int CTS_TYP_US = 20;
    localparam int CTS_CYCLES = (CTS_TYP_US * 1000) / CLK_PERIOD_NS;

    // command codes
    localparam logic [7:0] CMD_POLL_CTS = 8'h44;
    localparam logic [7:0] CMD_FAST_A = 8'h50;
    localparam logic [7:0] CMD_FAST_B = 8'h51;
    localparam logic [7:0] CMD_FAST_C = 8'h53;
    localparam logic [7:0] CMD_FAST_D = 8'h57;

    // clear-to-send answers and filler byte
    localparam logic [7:0] CTS_READY = 8'hff;
    localparam logic [7:0] CTS_WAIT = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    // first and last bit counter values
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // true for one of the four fast status read commands
    function automatic logic rsc_is_fast(input logic [7:0] cmd);
        return (cmd == CMD_FAST_A) || (cmd == CMD_FAST_B) ||
               (cmd == CMD_FAST_C) || (cmd == CMD_FAST_D);
    endfunction

    // position of the fast status byte a command selects
    function automatic logic [1:0] rsc_fast_index(input logic [7:0] cmd);
        logic [1:0] idx;
        idx = 2'h0;
        if (cmd == CMD_FAST_B) begin
            idx = 2'h1;
        end else if (cmd == CMD_FAST_C) begin
            idx = 2'h2;
        end else if (cmd == CMD_FAST_D) begin
            idx = 2'h3;
        end
        return idx;
    endfunction

endpackage

// ---- pkg/rsc_link_if.sv ----
// Purpose: four-wire serial link between host and radio port
// Assumes: output line idles high when the radio does not drive it
// Notes: resolves the output line from its enable, no tri-state here
`timescale 1ns/100ps
`default_nettype none
interface rsc_link_if;
    logic sclk;
    logic select_active_low;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // weak pull-up when the radio lets the line go
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport device (
        input sclk,
        input select_active_low,
        input sdi,
        output sdo,
        output sdo_oe
    );

    modport host (
        output sclk,
        output select_active_low,
        output sdi,
        input sdo_line
    );
endinterface
`default_nettype wire

// ---- verilog/rsc_device.sv ----
// Purpose: radio end of the serial command port (slave)
// Assumes: serial clock well below the 10 MHz system clock
// Notes: all link pins pass two flip-flops before use
`timescale 1ns/100ps
`default_nettype none
module rsc_device (
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // link
    rsc_link_if.device link,
    // fast status sources, byte 0 in the low bits
    input wire logic [31:0] i_fast_status,
    // response data handed out after a ready poll
    input wire logic [7:0] i_resp_data,
    output logic o_resp_take,
    // received command and parameters
    output logic o_cmd_valid,
    output logic [7:0] o_cmd,
    output logic o_param_valid,
    output logic [7:0] o_param,
    // controller still working on the last command
    output logic o_busy
);
    import rsc_pkg::*;

    typedef enum logic [1:0] {
        M_NONE,
        M_FAST,
        M_POLL,
        M_OTHER
    } rsc_mode_type;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic sel_s1;
        logic sel_s2;
        logic sel_s3;
        logic sdi_s1;
        logic sdi_s2;
        logic [2:0] bits;
        logic [7:0] rxsh;
        rsc_mode_type mode;
        logic [1:0] fidx;
        logic poll_ok;
        logic [3:0][7:0] snap;
        logic [7:0] txsh;
        logic sdo;
        logic sdo_oe;
        logic [7:0] busy_cnt;
        logic busy;
        logic resp_take;
        logic cmd_valid;
        logic [7:0] cmd;
        logic param_valid;
        logic [7:0] param;
    } rsc_dev_state_type;

    localparam rsc_dev_state_type DEV_RESET = '{
        sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
        sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1,
        sdi_s1: 1'b0, sdi_s2: 1'b0,
        bits: BIT_FIRST, rxsh: 8'h00, mode: M_NONE, fidx: 2'h0,
        poll_ok: 1'b0, snap: 32'h0000_0000, txsh: 8'h00,
        sdo: 1'b0, sdo_oe: 1'b0, busy_cnt: 8'h00, busy: 1'b0,
        resp_take: 1'b0, cmd_valid: 1'b0, cmd: 8'h00,
        param_valid: 1'b0, param: 8'h00
    };

    rsc_dev_state_type r_reg;
    rsc_dev_state_type r_next;

    // next state
    always_comb begin
        logic [7:0] byte_in;
        logic sclk_rise;
        logic sclk_fall;
        logic sel_fall;
        logic sel_rise;
        byte_in = {r_reg.rxsh[6:0], r_reg.sdi_s2};
        sclk_rise = !r_reg.sclk_s3 && r_reg.sclk_s2;
        sclk_fall = r_reg.sclk_s3 && !r_reg.sclk_s2;
        sel_fall = r_reg.sel_s3 && !r_reg.sel_s2;
        sel_rise = !r_reg.sel_s3 && r_reg.sel_s2;
        r_next = r_reg;
        r_next.cmd_valid = 1'b0;
        r_next.param_valid = 1'b0;
        r_next.resp_take = 1'b0;

        // pin synchronisers; first stage feeds only the second
        r_next.sclk_s1 = link.sclk;
        r_next.sclk_s2 = r_reg.sclk_s1;
        r_next.sclk_s3 = r_reg.sclk_s2;
        r_next.sel_s1 = link.select_active_low;
        r_next.sel_s2 = r_reg.sel_s1;
        r_next.sel_s3 = r_reg.sel_s2;
        r_next.sdi_s1 = link.sdi;
        r_next.sdi_s2 = r_reg.sdi_s1;

        // internal controller time to finish a command
        if (r_reg.busy_cnt != 8'h00) begin
            r_next.busy_cnt = r_reg.busy_cnt - 8'h01;
        end

        if (sel_fall) begin
            // new transaction; status bytes frozen until next select fall
            r_next.bits = BIT_FIRST;
            r_next.mode = M_NONE;
            r_next.poll_ok = 1'b0;
            r_next.snap = i_fast_status;
            r_next.txsh = FILL_BYTE;
            r_next.sdo = 1'b0;
            r_next.sdo_oe = 1'b1;
        end else if (sel_rise) begin
            // end of transaction; a real command makes us busy
            r_next.sdo_oe = 1'b0;
            if (r_reg.mode == M_OTHER) begin
                r_next.busy_cnt = 8'(CTS_CYCLES);
            end
        end else if (!r_reg.sel_s2) begin
            if (sclk_rise) begin
                // capture data on the rising edge
                r_next.rxsh = byte_in;
                r_next.bits = r_reg.bits + 3'h1;
                if (r_reg.bits == BIT_LAST) begin
                    case (r_reg.mode)
                        M_NONE: begin
                            // first byte is always the command
                            r_next.cmd_valid = 1'b1;
                            r_next.cmd = byte_in;
                            if (rsc_is_fast(byte_in)) begin
                                r_next.mode = M_FAST;
                                r_next.txsh =
                                    r_reg.snap[rsc_fast_index(byte_in)];
                                r_next.fidx =
                                    rsc_fast_index(byte_in) + 2'h1;
                            end else if (byte_in == CMD_POLL_CTS) begin
                                r_next.mode = M_POLL;
                                r_next.poll_ok = !r_reg.busy;
                                r_next.txsh = r_reg.busy ? CTS_WAIT
                                                         : CTS_READY;
                            end else begin
                                r_next.mode = M_OTHER;
                                r_next.txsh = FILL_BYTE;
                            end
                        end
                        M_FAST: begin
                            // burst wraps round the four bytes
                            r_next.txsh = r_reg.snap[r_reg.fidx];
                            r_next.fidx = r_reg.fidx + 2'h1;
                        end
                        M_POLL: begin
                            // data follows only a ready answer
                            if (r_reg.poll_ok) begin
                                r_next.txsh = i_resp_data;
                                r_next.resp_take = 1'b1;
                            end else begin
                                r_next.txsh = FILL_BYTE;
                            end
                        end
                        default: begin
                            r_next.param_valid = 1'b1;
                            r_next.param = byte_in;
                            r_next.txsh = FILL_BYTE;
                        end
                    endcase
                end
            end else if (sclk_fall) begin
                // drive the next bit on the falling edge
                r_next.sdo = r_reg.txsh[7];
                r_next.txsh = {r_reg.txsh[6:0], 1'b0};
            end
        end

        r_next.busy = r_next.busy_cnt != 8'h00;
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= DEV_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign link.sdo = r_reg.sdo;
    assign link.sdo_oe = r_reg.sdo_oe;
    assign o_resp_take = r_reg.resp_take;
    assign o_cmd_valid = r_reg.cmd_valid;
    assign o_cmd = r_reg.cmd;
    assign o_param_valid = r_reg.param_valid;
    assign o_param = r_reg.param;
    assign o_busy = r_reg.busy;

endmodule
`default_nettype wire

// ---- verilog/rsc_host.sv ----
// Purpose: host end of the serial command port (master)
// Assumes: device answers as the radio end does
// Notes: makes the serial clock by dividing the system clock
`timescale 1ns/100ps
`default_nettype none
module rsc_host (
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // link
    rsc_link_if.host link,
    // command request, taken when idle
    input wire logic i_start,
    input wire logic [7:0] i_cmd,
    input wire logic [3:0] i_wr_len,
    input wire logic [3:0] i_rd_len,
    // parameter feed, sampled with the take pulse
    input wire logic [7:0] i_param,
    output logic o_param_take,
    // response bytes and status
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_done,
    output logic o_busy
);
    import rsc_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE,
        H_XFER,
        H_NEXT,
        H_DESEL
    } rsc_hstate_type;

    typedef enum logic [2:0] {
        K_CMD,
        K_PARAM,
        K_POLL,
        K_CTS,
        K_READ
    } rsc_kind_type;

    typedef struct packed {
        rsc_hstate_type st;
        rsc_kind_type kind;
        logic fast;
        logic sclk;
        logic sel_n;
        logic sdi;
        logic sdo_s1;
        logic sdo_s2;
        logic [3:0] cnt;
        logic [2:0] bits;
        logic [7:0] txsh;
        logic [7:0] rxsh;
        logic [3:0] wr_left;
        logic [3:0] rd_left;
        logic param_take;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic done;
        logic busy;
    } rsc_host_state_type;

    localparam rsc_host_state_type HOST_RESET = '{
        st: H_IDLE, kind: K_CMD, fast: 1'b0, sclk: 1'b0, sel_n: 1'b1,
        sdi: 1'b0, sdo_s1: 1'b1, sdo_s2: 1'b1, cnt: 4'h0,
        bits: BIT_FIRST, txsh: 8'h00, rxsh: 8'h00, wr_left: 4'h0,
        rd_left: 4'h0, param_take: 1'b0, rx_valid: 1'b0,
        rx_byte: 8'h00, done: 1'b0, busy: 1'b0
    };

    rsc_host_state_type r_reg;
    rsc_host_state_type r_next;

    // next state
    always_comb begin
        logic [7:0] byte_in;
        logic load;
        logic [7:0] load_byte;
        byte_in = {r_reg.rxsh[6:0], r_reg.sdo_s2};
        load = 1'b0;
        load_byte = FILL_BYTE;
        r_next = r_reg;
        r_next.param_take = 1'b0;
        r_next.rx_valid = 1'b0;
        r_next.done = 1'b0;
        r_next.sdo_s1 = link.sdo_line;
        r_next.sdo_s2 = r_reg.sdo_s1;

        case (r_reg.st)
            H_IDLE: begin
                if (i_start) begin
                    // every command opens with select low
                    r_next.sel_n = 1'b0;
                    r_next.kind = K_CMD;
                    r_next.fast = rsc_is_fast(i_cmd);
                    r_next.wr_left = i_wr_len;
                    r_next.rd_left = i_rd_len;
                    load = 1'b1;
                    load_byte = i_cmd;
                end
            end
            H_XFER: begin
                if (r_reg.cnt != 4'h0) begin
                    r_next.cnt = r_reg.cnt - 4'h1;
                end else if (!r_reg.sclk) begin
                    // divided clock, never above the 10 MHz limit
                    r_next.sclk = 1'b1;
                    r_next.cnt = 4'(SCLK_HALF_CYCLES - 1);
                end else begin
                    // sample late: synchroniser adds two cycles
                    r_next.sclk = 1'b0;
                    r_next.cnt = 4'(SCLK_HALF_CYCLES - 1);
                    r_next.rxsh = byte_in;
                    if (r_reg.bits == BIT_LAST) begin
                        r_next.st = H_NEXT;
                    end else begin
                        // new bit centred on the next rising edge
                        r_next.bits = r_reg.bits + 3'h1;
                        r_next.sdi = r_reg.txsh[6];
                        r_next.txsh = {r_reg.txsh[6:0], 1'b0};
                    end
                end
            end
            H_NEXT: begin
                if (r_reg.kind == K_READ) begin
                    r_next.rx_valid = 1'b1;
                    r_next.rx_byte = r_reg.rxsh;
                    r_next.rd_left = r_reg.rd_left - 4'h1;
                end
                if (r_reg.kind == K_CTS && r_reg.rxsh != CTS_READY) begin
                    // not ready: close and poll again later
                    r_next.st = H_DESEL;
                end else if (r_reg.wr_left != 4'h0) begin
                    r_next.kind = K_PARAM;
                    r_next.wr_left = r_reg.wr_left - 4'h1;
                    r_next.param_take = 1'b1;
                    load = 1'b1;
                    load_byte = i_param;
                end else if (r_reg.kind == K_POLL) begin
                    r_next.kind = K_CTS;
                    load = 1'b1;
                end else if ((r_reg.fast || r_reg.kind == K_CTS ||
                              r_reg.kind == K_READ) &&
                             r_next.rd_left != 4'h0) begin
                    // data clocked after a ready answer, or straight after a fast command
                    r_next.kind = K_READ;
                    load = 1'b1;
                end else begin
                    r_next.st = H_DESEL;
                end
                if (r_next.st == H_DESEL) begin
                    r_next.sel_n = 1'b1;
                    r_next.cnt = 4'(SEL_GAP_CYCLES - 1);
                end
            end
            default: begin
                if (r_reg.cnt != 4'h0) begin
                    r_next.cnt = r_reg.cnt - 4'h1;
                end else if (!r_reg.fast && r_reg.rd_left != 4'h0) begin
                    // fresh transaction for each poll
                    r_next.sel_n = 1'b0;
                    r_next.kind = K_POLL;
                    load = 1'b1;
                    load_byte = CMD_POLL_CTS;
                end else begin
                    r_next.st = H_IDLE;
                    r_next.done = 1'b1;
                end
            end
        endcase

        // start a byte: first bit out, half a period to the first rise
        if (load) begin
            r_next.st = H_XFER;
            r_next.sdi = load_byte[7];
            r_next.txsh = load_byte;
            r_next.bits = BIT_FIRST;
            r_next.sclk = 1'b0;
            r_next.cnt = 4'(SCLK_HALF_CYCLES - 1);
        end
        r_next.busy = r_next.st != H_IDLE;
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= HOST_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign link.sclk = r_reg.sclk;
    assign link.select_active_low = r_reg.sel_n;
    assign link.sdi = r_reg.sdi;
    assign o_param_take = r_reg.param_take;
    assign o_rx_valid = r_reg.rx_valid;
    assign o_rx_byte = r_reg.rx_byte;
    assign o_done = r_reg.done;
    assign o_busy = r_reg.busy;

endmodule
`default_nettype wire

// ---- verification/rsc_link_properties.sv ----
// Purpose: timing checks on the serial link between host and radio ends
// Assumes: the system clock samples every link line
// Notes: sees only the interface lines, no design internals
`timescale 1ns/100ps
`default_nettype none
module rsc_link_properties (
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // link lines
    input wire logic sclk,
    input wire logic select_active_low,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    logic [2:0] rise_cnt;
    logic sclk_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // clock rises in a transaction, so a cut byte shows at select rise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rise_cnt <= 3'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
            if (select_active_low) begin
                rise_cnt <= 3'h0;
            end else if (sclk && !sclk_d) begin
                rise_cnt <= rise_cnt + 3'h1;
            end
        end
    end

    a_sclk_idle_low: assert property (
        select_active_low |-> !sclk)
        else $error("serial clock moved while deselected");
    a_first_bit_setup: assert property (
        $fell(select_active_low) |-> !sclk [*4] ##1 sclk)
        else $error("first clock rise not four cycles after select");
    a_sclk_high_time: assert property (
        $rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    a_sclk_low_time: assert property (
        $fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    a_sdi_held_high: assert property (
        sclk |-> $stable(sdi))
        else $error("data in changed while clock high");
    a_sdo_on_fall: assert property (
        sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sclk && !$past(sclk))
        else $error("data out changed outside the low phase");
    a_sdo_drive_on: assert property (
        $fell(select_active_low) |-> ##[1:4] sdo_oe)
        else $error("data out not driven after select");
    a_sdo_release: assert property (
        $rose(select_active_low) |-> ##[1:4] (!sdo_oe && sdo_line))
        else $error("data out not released after select");
    a_select_gap: assert property (
        $rose(select_active_low) |-> select_active_low [*8])
        else $error("select high gap shorter than eight cycles");
    a_whole_bytes: assert property (
        $rose(select_active_low) |-> rise_cnt == 3'h0)
        else $error("transaction ended inside a byte");
endmodule
`default_nettype wire

// ---- verification/test_radio_spi_command_port.sv ----
// Purpose: self-checking bench, host and radio ends joined by the link
// Assumes: 10 MHz clock, inputs driven 1 ns after the rising edge
// Notes: link lines are decoded here to check framing and bit order
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    fails++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_radio_spi_command_port;
    import rsc_pkg::*;
    typedef struct {
        logic [7:0] cmd;
        logic [3:0] wr;
        logic [3:0] rd;
        logic fast;
        logic [1:0] fidx;
        int tmin;
        int tmax;
        logic busy;
    } rsc_row_type;
    logic clk, rst, start, sclk_d, sel_d;
    logic [7:0] cmd, sh_in, sh_out, param_in, resp_in, h_rx, d_cmd, d_par;
    logic [3:0] wr_len, rd_len, pidx, ridx;
    logic [31:0] stat, stat0;
    logic h_take, h_rxv, h_done, h_busy, d_take, d_cmdv, d_parv, d_busy;
    logic [7:0] w_in[$], w_out[$], q_cmd[$], q_par[$], q_rx[$];
    int fails, total_checks, nbit, ntr;
    rsc_row_type rows [6];
    rsc_link_if link_bus ();

    rsc_host i_rsc_host (.i_clk(clk), .i_rst(rst), .link(link_bus.host),
        .i_start(start), .i_cmd(cmd), .i_wr_len(wr_len), .i_rd_len(rd_len),
        .i_param(param_in), .o_param_take(h_take), .o_rx_valid(h_rxv),
        .o_rx_byte(h_rx), .o_done(h_done), .o_busy(h_busy));
    rsc_device i_rsc_device (.i_clk(clk), .i_rst(rst), .link(link_bus.device),
        .i_fast_status(stat), .i_resp_data(resp_in), .o_resp_take(d_take),
        .o_cmd_valid(d_cmdv), .o_cmd(d_cmd), .o_param_valid(d_parv),
        .o_param(d_par), .o_busy(d_busy));
    rsc_link_properties u_props (.i_clk(clk), .i_rst(rst),
        .sclk(link_bus.sclk), .select_active_low(link_bus.select_active_low),
        .sdi(link_bus.sdi), .sdo(link_bus.sdo), .sdo_oe(link_bus.sdo_oe),
        .sdo_line(link_bus.sdo_line));

    // parameter and response feeds step on each take pulse
    assign param_in = 8'ha0 + {4'h0, pidx};
    assign resp_in = 8'hc0 + {4'h0, ridx};

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // link decoder and output collectors, all sampled before the edge lands
    always @(posedge clk) begin
        if (link_bus.select_active_low) begin
            nbit = 0;
        end else if (link_bus.sclk && !sclk_d) begin
            sh_in = {sh_in[6:0], link_bus.sdi};
            sh_out = {sh_out[6:0], link_bus.sdo_line};
            nbit++;
            if (nbit == 8) begin
                w_in.push_back(sh_in);
                w_out.push_back(sh_out);
                nbit = 0;
            end
        end
        if (!link_bus.select_active_low && sel_d) ntr++;
        sclk_d = link_bus.sclk;
        sel_d = link_bus.select_active_low;
        // polls are counted on the wire, not taken as commands here
        if (d_cmdv && d_cmd !== CMD_POLL_CTS) q_cmd.push_back(d_cmd);
        if (d_parv) q_par.push_back(d_par);
        if (h_rxv) q_rx.push_back(h_rx);
        // feeds move off the sampling edge, never under a take
        if (h_take) pidx <= pidx + 4'h1;
        if (d_take) ridx <= ridx + 4'h1;
    end

    task automatic summarize();
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one command; a stray start mid-run must be ignored
    task automatic run_row(input rsc_row_type r);
        logic [7:0] e;
        logic [1:0] k;
        int n;
        n = 0;
        w_in = {};
        w_out = {};
        q_cmd = {};
        q_par = {};
        q_rx = {};
        pidx = 4'h0;
        ridx = 4'h0;
        ntr = 0;
        stat0 = stat;
        @(posedge clk);
        #1;
        start = 1'b1;
        cmd = r.cmd;
        wr_len = r.wr;
        rd_len = r.rd;
        @(posedge clk);
        #1;
        start = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        start = 1'b1;
        cmd = 8'h99;
        // snapshot was taken at select fall, so this must not show
        if (r.fast) stat = ~stat;
        @(posedge clk);
        #1;
        start = 1'b0;
        // done is looked at once it has settled after its edge
        while (h_done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (h_done !== 1'b1) begin
            // limit used up: counted here, verdict given at the end
            fails++;
            return;
        end
        `CHK("host busy at done", 1'b0, h_busy) // idle with done
        `CHK("transactions", 1'b1, ntr >= r.tmin && ntr <= r.tmax)
        `CHK("wire cmd", r.cmd, w_in[0]) // command leads
        `CHK("dev cmd count", 32'd1, q_cmd.size())
        `CHK("dev cmd", r.cmd, q_cmd[0])
        `CHK("dev param count", 32'(r.wr), q_par.size())
        for (int j = 0; j < r.wr; j++) begin
            e = 8'ha0 + 8'(j);
            `CHK("wire param", e, w_in[j + 1]) // msb first
            `CHK("dev param", e, q_par[j])
        end
        `CHK("rx count", 32'(r.rd), q_rx.size())
        for (int j = 0; j < r.rd; j++) begin
            k = r.fidx + j[1:0];
            e = r.fast ? stat0[8 * k +: 8] : 8'hc0 + 8'(j);
            `CHK("host rx", e, q_rx[j])
            if (r.fast) `CHK("wire out", e, w_out[j + 1])
        end
        `CHK("dev busy", r.busy, d_busy)
        `CHK("idle clock", 1'b0, link_bus.sclk)
    endtask

    initial begin
        rst = 1'b1;
        start = 1'b0;
        cmd = 8'h00;
        wr_len = 4'h0;
        rd_len = 4'h0;
        stat = 32'hd4c3b2a1;
        pidx = 4'h0;
        ridx = 4'h0;
        sclk_d = 1'b0;
        sel_d = 1'b1;
        nbit = 0;
        ntr = 0;
        fails = 0;
        total_checks = 0;
        // write, read while busy (polls retried), then every fast code
        rows = '{'{8'h12, 4'h3, 4'h0, 1'b0, 2'h0, 1, 1, 1'b1},
                 '{8'h23, 4'h1, 4'h2, 1'b0, 2'h0, 3, 5, 1'b0},
                 '{CMD_FAST_A, 4'h0, 4'h5, 1'b1, 2'h0, 1, 1, 1'b0},
                 '{CMD_FAST_B, 4'h0, 4'h5, 1'b1, 2'h1, 1, 1, 1'b0},
                 '{CMD_FAST_C, 4'h0, 4'h5, 1'b1, 2'h2, 1, 1, 1'b0},
                 '{CMD_FAST_D, 4'h0, 4'h6, 1'b1, 2'h3, 1, 1, 1'b0}};
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        // reset in mid-burst, then the same fast command must work again
        @(posedge clk);
        #1;
        start = 1'b1;
        cmd = CMD_FAST_B;
        @(posedge clk);
        #1;
        start = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        `CHK("reset select", 1'b1, link_bus.select_active_low)
        `CHK("reset sclk", 1'b0, link_bus.sclk)
        `CHK("reset sdo_oe", 1'b0, link_bus.sdo_oe)
        `CHK("reset busy", 1'b0, h_busy || d_busy)
        rst = 1'b0;
        run_row(rows[3]);
        summarize();
    end
endmodule
`default_nettype wire
